/* File: core/all_cfg.svh */
// holds the constants of the lite slave port and its master end
// assumes inclusion by the package and both end modules
// Behaviour
// - one data beat per transaction only
// - full fixed 32 or 64 bit bus
// - accesses non-modifiable, non-bufferable always
// - slave never answers exclusive okay
// - all accesses normal, no lock
// - every beat is the last beat
// - no burst type, slave ignores it
// - master drives correct write strobes
// - slave picks one strobe policy
// - memory slave honours every strobe pattern; here only under ALL_POL_FULL, not ignore or detect
// - all-zero strobe write still answered
// - outstanding allowed, limited by ready only
// - in order, one fixed id otherwise
// - capture id per address, return it
// - write id taken from address channel
// - 64-bit slave sees all accesses wide
// - only lite signals carried on interface; all_if also carries awid, bid, arid and rid
// - direct full master needs id reflection
`ifndef ALL_CFG_SVH
`define ALL_CFG_SVH
`define ALL_DATA_W 32
`define ALL_STRB_W 4
`define ALL_ADDR_W 12
`define ALL_ID_W 4
`define ALL_MEM_WORDS 64
`define ALL_MEM_AW 6
`define ALL_WORD_LSB 2
`define ALL_QDEPTH 4
`define ALL_QPTR_W 2
`define ALL_QCNT_W 3
`define ALL_RESP_OKAY 2'h0
`define ALL_RESP_EXOKAY 2'h1
`define ALL_RESP_SLVERR 2'h2
`define ALL_POL_FULL 2'h0
`define ALL_POL_IGNORE 2'h1
`define ALL_POL_DETECT 2'h2
`endif

/* File: core/all_if.sv */
// interface joining the lite master end and the slave end
// assumes one clock and an active-high asynchronous reset
`timescale 1ns/1ns
`include "all_cfg.svh"
interface all_if (
   input wire logic sys_clk,
   input wire logic rst
);
   import all_pkg::*;
   // only lite signals plus optional ids
   logic awvalid;
   logic awready;
   all_addr_type awaddr;
   all_prot_type awprot;
   all_id_type awid;
   logic wvalid;
   logic wready;
   all_data_type wdata;
   all_strb_type wstrb;
   logic bvalid;
   logic bready;
   all_resp_type bresp;
   all_id_type bid;
   logic arvalid;
   logic arready;
   all_addr_type araddr;
   all_prot_type arprot;
   all_id_type arid;
   logic rvalid;
   logic rready;
   all_data_type rdata;
   all_resp_type rresp;
   all_id_type rid;
   modport mst (
      input awready, wready, bvalid, bresp, bid,
      input arready, rvalid, rdata, rresp, rid,
      output awvalid, awaddr, awprot, awid, wvalid, wdata, wstrb, bready,
      output arvalid, araddr, arprot, arid, rready
   );
   modport slv (
      output awready, wready, bvalid, bresp, bid,
      output arready, rvalid, rdata, rresp, rid,
      input awvalid, awaddr, awprot, awid, wvalid, wdata, wstrb, bready,
      input arvalid, araddr, arprot, arid, rready
   );
endinterface

/* File: core/all_master.sv */
// lite master end: turns one user request into one single-beat access
// assumes the slave end across all_if; one access at a time
`timescale 1ns/1ns
`include "all_cfg.svh"
module all_master (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic req,
   input wire logic req_write,
   input wire all_pkg::all_addr_type req_addr,
   input wire all_pkg::all_data_type req_wdata,
   input wire all_pkg::all_strb_type req_strb,
   input wire all_pkg::all_id_type req_id,
   output logic busy,
   output logic done,
   output all_pkg::all_data_type done_rdata,
   output all_pkg::all_resp_type done_resp,
   output all_pkg::all_id_type done_id,
   all_if.mst bus
);
   import all_pkg::*;

   // -----------------------------------------
   // state
   // -----------------------------------------
   typedef struct packed {
      all_mst_type st;
      logic busy;
      logic wr;
      logic awvalid;
      logic wvalid;
      logic arvalid;
      logic bready;
      logic rready;
      all_addr_type addr;
      all_data_type wdata;
      all_strb_type wstrb;
      all_id_type id;
      logic done;
      all_data_type rdata;
      all_resp_type resp;
      all_id_type rid;
   } all_m_type;

   all_m_type m_r;
   all_m_type m_nxt;

   always_comb begin
      m_nxt = m_r;
      m_nxt.done = 1'b0;
      unique case (m_r.st)
         ALL_M_IDLE: begin
            if (req) begin
               m_nxt.st = ALL_M_BUSY;
               m_nxt.wr = req_write;
               m_nxt.addr = req_addr;
               m_nxt.wdata = req_wdata;
               m_nxt.wstrb = req_strb; // correct strobes from user
               m_nxt.id = req_id;
               m_nxt.awvalid = req_write;
               m_nxt.wvalid = req_write;
               m_nxt.arvalid = ~req_write;
               m_nxt.bready = req_write;
               m_nxt.rready = ~req_write;
            end
         end
         ALL_M_BUSY: begin
            if (bus.awready) m_nxt.awvalid = 1'b0;
            if (bus.wready) m_nxt.wvalid = 1'b0;
            if (bus.arready) m_nxt.arvalid = 1'b0;
            // one response ends the access, every beat is last
            if (m_r.wr && bus.bvalid && m_r.bready) begin
               m_nxt.st = ALL_M_DONE;
               m_nxt.bready = 1'b0;
               m_nxt.resp = bus.bresp;
               m_nxt.rid = bus.bid;
               m_nxt.done = 1'b1;
            end else if (!m_r.wr && bus.rvalid && m_r.rready) begin
               m_nxt.st = ALL_M_DONE;
               m_nxt.rready = 1'b0;
               m_nxt.rdata = bus.rdata;
               m_nxt.resp = bus.rresp;
               m_nxt.rid = bus.rid;
               m_nxt.done = 1'b1;
            end
         end
         ALL_M_DONE: m_nxt.st = ALL_M_IDLE;
      endcase
      // busy leaves a flop so the user side sees no decode glitch
      m_nxt.busy = (m_nxt.st != ALL_M_IDLE);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         m_r <= '0;
         m_r.st <= ALL_M_IDLE;
      end else begin
         m_r <= m_nxt;
      end
   end

   // no len, size, burst, lock or cache exist here
   assign bus.awvalid = m_r.awvalid;
   assign bus.awaddr = m_r.addr;
   assign bus.awprot = 3'h0;
   assign bus.awid = m_r.id;
   assign bus.wvalid = m_r.wvalid;
   assign bus.wdata = m_r.wdata;
   assign bus.wstrb = m_r.wstrb;
   assign bus.bready = m_r.bready;
   assign bus.arvalid = m_r.arvalid;
   assign bus.araddr = m_r.addr;
   assign bus.arprot = 3'h0;
   assign bus.arid = m_r.id;
   assign bus.rready = m_r.rready;
   assign busy = m_r.busy;
   assign done = m_r.done;
   assign done_rdata = m_r.rdata;
   assign done_resp = m_r.resp;
   assign done_id = m_r.rid;
endmodule

/* File: core/all_pkg.sv */
// holds the types shared by both ends
// assumes all_cfg.svh on the include path
`include "all_cfg.svh"
package all_pkg;
   typedef logic [`ALL_DATA_W-1:0] all_data_type;
   typedef logic [`ALL_STRB_W-1:0] all_strb_type;
   typedef logic [`ALL_ADDR_W-1:0] all_addr_type;
   typedef logic [`ALL_ID_W-1:0] all_id_type;
   typedef logic [1:0] all_resp_type;
   typedef logic [2:0] all_prot_type;
   typedef enum logic [2:0] {
      ALL_M_IDLE = 3'h1,
      ALL_M_BUSY = 3'h2,
      ALL_M_DONE = 3'h4
   } all_mst_type;
endpackage

/* File: core/all_slave.sv */
// lite slave end: word memory with id reflection
// assumes a master keeping to the lite subset, single beats
`timescale 1ns/1ns
`include "all_cfg.svh"
module all_slave (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] strb_policy,
   output logic [7:0] wr_count,
   all_if.slv bus
);
   import all_pkg::*;
   localparam int QD = `ALL_QDEPTH;

   // -----------------------------------------
   // state
   // -----------------------------------------
   typedef struct packed {
      // channel outputs
      logic awready;
      logic wready;
      logic bvalid;
      all_resp_type bresp;
      all_id_type bid;
      logic arready;
      logic rvalid;
      all_data_type rdata;
      all_resp_type rresp;
      all_id_type rid;
      // held halves of a write
      logic aw_held;
      all_addr_type aw_addr;
      logic w_held;
      all_data_type w_data;
      all_strb_type w_strb;
      // write id queue, head at index 0
      logic [QD-1:0][`ALL_ID_W-1:0] wq;
      logic [`ALL_QCNT_W-1:0] wq_cnt;
      // completed writes, wrapping
      logic [7:0] wr_count;
   } all_slv_type;

   all_slv_type s_r;
   all_slv_type s_nxt;
   all_data_type mem [`ALL_MEM_WORDS];
   logic mem_we;
   logic [`ALL_MEM_AW-1:0] mem_wa;
   wire all_data_type mem_wd;
   all_data_type mem_rd;
   logic [`ALL_MEM_AW-1:0] mem_ra;
   all_data_type old_wd;
   logic aw_acc;
   logic w_acc;
   logic ar_acc;
   logic b_pop;
   logic r_pop;
   logic do_wr;
   logic bad_strb;
   all_strb_type eff_strb;
   wire [QD-1:0][`ALL_ID_W-1:0] wq_push;
   wire [QD-1:0][`ALL_ID_W-1:0] wq_next;

   // -----------------------------------------
   // handshakes
   // -----------------------------------------
   assign aw_acc = bus.awvalid & s_r.awready;
   assign w_acc = bus.wvalid & s_r.wready;
   assign ar_acc = bus.arvalid & s_r.arready;
   assign b_pop = s_r.bvalid & bus.bready;
   assign r_pop = s_r.rvalid & bus.rready;
   // a write needs both halves held and a free response slot
   assign do_wr = s_r.aw_held & s_r.w_held & (~s_r.bvalid | b_pop);

   // -----------------------------------------
   // storage ports
   // -----------------------------------------
   // read data is taken in the accept cycle, so a write landing on the
   // same edge is not seen; the single master never overlaps the two
   assign mem_ra = bus.araddr[`ALL_WORD_LSB +: `ALL_MEM_AW];
   assign mem_rd = mem[mem_ra];
   assign mem_wa = s_r.aw_addr[`ALL_WORD_LSB +: `ALL_MEM_AW];
   assign mem_we = do_wr; // zero strobes still answered
   assign old_wd = mem[mem_wa];

   // -----------------------------------------
   // strobe policy
   // -----------------------------------------
   // detect passes only whole words or none
   assign bad_strb = (strb_policy == `ALL_POL_DETECT) &&
                     (s_r.w_strb != '1) && (s_r.w_strb != '0);

   always_comb begin
      unique case (strb_policy)
         `ALL_POL_IGNORE: eff_strb = '1; // full width writes
         `ALL_POL_DETECT: eff_strb = bad_strb ? '0 : s_r.w_strb;
         default: eff_strb = s_r.w_strb; // honour every byte
      endcase
   end

   // -----------------------------------------
   // byte lanes
   // -----------------------------------------
   // a lane without its strobe rewrites the stored byte: one word-wide
   // array with a read port, instead of one array per byte lane
   for (genvar g = 0; g < `ALL_STRB_W; g++) begin : gen_lane
      assign mem_wd[g*8 +: 8] = eff_strb[g] ? s_r.w_data[g*8 +: 8] :
                                old_wd[g*8 +: 8];
   end

   // -----------------------------------------
   // write id queue
   // -----------------------------------------
   // push at the fill level, shift one place as a write completes;
   // depth 4 is more than the single held address needs, but keeps
   // the pairing safe if the address slot is ever deepened
   for (genvar g = 0; g < QD; g++) begin : gen_wq
      assign wq_push[g] = (aw_acc && s_r.wq_cnt == `ALL_QCNT_W'(g)) ?
                          bus.awid : s_r.wq[g];
      if (g < QD - 1) begin : gen_mid
         assign wq_next[g] = do_wr ? wq_push[g+1] : wq_push[g];
      end else begin : gen_top
         assign wq_next[g] = wq_push[g];
      end
   end

   // -----------------------------------------
   // next state
   // -----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.wq = wq_next;
      // write queue: id captured from the address channel
      if (aw_acc) begin
         s_nxt.aw_held = 1'b1;
         s_nxt.aw_addr = bus.awaddr;
         s_nxt.wq_cnt = s_r.wq_cnt + 1'b1;
      end
      if (w_acc) begin // each beat is the last
         s_nxt.w_held = 1'b1;
         s_nxt.w_data = bus.wdata;
         s_nxt.w_strb = bus.wstrb;
      end
      // both halves held: write, answer and pop the id
      if (do_wr) begin
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held = 1'b0;
         s_nxt.bvalid = 1'b1;
         // never exclusive okay
         s_nxt.bresp = bad_strb ? `ALL_RESP_SLVERR : `ALL_RESP_OKAY;
         s_nxt.bid = s_r.wq[0];
         s_nxt.wr_count = s_r.wr_count + 8'h01;
         s_nxt.wq_cnt = s_nxt.wq_cnt - 1'b1;
      end else if (b_pop) begin
         s_nxt.bvalid = 1'b0;
      end
      // limit outstanding work only by ready
      // the address slot frees in the cycle its write completes
      s_nxt.awready = ~s_nxt.aw_held &&
                      (s_nxt.wq_cnt < `ALL_QCNT_W'(QD));
      s_nxt.wready = ~s_nxt.w_held;
      // read: one beat, always the full bus width
      if (ar_acc) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = mem_rd;
         s_nxt.rresp = `ALL_RESP_OKAY;
         s_nxt.rid = bus.arid;
      end else if (r_pop) begin
         s_nxt.rvalid = 1'b0;
      end
      // single read slot keeps reads in order, no interleave
      // the slot also carries the read id, a queue one deep
      s_nxt.arready = ~s_nxt.rvalid;
   end

   // -----------------------------------------
   // registers
   // -----------------------------------------
   // readies stay low in reset and rise on the first edge after it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // memory holds no reset; it is storage, not control
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // -----------------------------------------
   // outputs
   // -----------------------------------------
   // every output comes straight from a register
   assign bus.awready = s_r.awready;
   assign bus.wready = s_r.wready;
   assign bus.bvalid = s_r.bvalid;
   assign bus.bresp = s_r.bresp;
   assign bus.bid = s_r.bid;
   assign bus.arready = s_r.arready;
   assign bus.rvalid = s_r.rvalid;
   assign bus.rdata = s_r.rdata;
   assign bus.rresp = s_r.rresp;
   assign bus.rid = s_r.rid;
   assign wr_count = s_r.wr_count;
endmodule

/* File: test/all_properties.sv */
// ---------------------------------------------------------------
// checker of the lite link between master end and slave end
// ---------------------------------------------------------------
// assumes one master issuing one access at a time over all_if
`timescale 1ns/1ns
`include "all_cfg.svh"
module all_properties (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic awvalid,
   input wire logic awready,
   input wire all_pkg::all_id_type awid,
   input wire logic bvalid,
   input wire logic bready,
   input wire all_pkg::all_resp_type bresp,
   input wire all_pkg::all_id_type bid,
   input wire logic arvalid,
   input wire logic arready,
   input wire all_pkg::all_id_type arid,
   input wire logic rvalid,
   input wire logic rready,
   input wire all_pkg::all_resp_type rresp,
   input wire all_pkg::all_id_type rid
);
   import all_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // ---------------------------------------------------------------
   // helper: id of the last accepted write address
   // ---------------------------------------------------------------
   // one outstanding write only, so no queue is modelled here
   all_id_type awid_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         awid_r <= 4'h0;
      end else if (awvalid && awready) begin
         awid_r <= awid;
      end
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_no_exokay_b: assert property (
      bvalid |-> bresp != `ALL_RESP_EXOKAY) else $error("write exokay");
   a_no_exokay_r: assert property (
      rvalid |-> rresp != `ALL_RESP_EXOKAY) else $error("read exokay");
   a_bid_reflect: assert property (
      bvalid |-> bid == awid_r) else $error("bid not awid");
   a_rid_reflect: assert property (
      (arvalid && arready) |=> rvalid && rid == $past(arid))
      else $error("rid not arid");
   a_b_stands: assert property (
      (bvalid && !bready) |=> bvalid && $stable(bid) && $stable(bresp))
      else $error("write response dropped");
   a_write_answer: assert property (
      (awvalid && awready) |-> ##[1:20] bvalid) else $error("no bvalid");
   a_rd_in_order: assert property (
      rvalid |-> !arready) else $error("read accepted while busy");
   a_b_single: assert property (
      (bvalid && bready) |=> !bvalid) else $error("second response beat");
   a_aw_withheld: assert property (
      (awvalid && awready) |=> !awready)
      else $error("address slot not held");
   a_r_single: assert property (
      (rvalid && rready) |=> !rvalid) else $error("second read beat");
endmodule

/* File: test/testbench.sv */
// ---------------------------------------------------------------
// testbench: master end and slave end joined by all_if
// ---------------------------------------------------------------
// assumes the user side of the master, strb_policy and rst as its only stimulus paths
`timescale 1ns/1ns
`include "all_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   import all_pkg::*;
   logic sys_clk;
   logic rst;
   logic req;
   logic req_write;
   all_addr_type req_addr;
   all_data_type req_wdata;
   all_strb_type req_strb;
   all_id_type req_id;
   logic [1:0] strb_policy;
   logic busy;
   logic done;
   all_data_type done_rdata;
   all_resp_type done_resp;
   all_id_type done_id;
   logic [7:0] wr_count;
   int bad_count;
   int cmp_count;
   all_if bus_if (.sys_clk(sys_clk), .rst(rst));
   all_master all_master_inst (.sys_clk(sys_clk), .rst(rst), .req(req),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_strb(req_strb), .req_id(req_id), .busy(busy), .done(done),
      .done_rdata(done_rdata), .done_resp(done_resp), .done_id(done_id),
      .bus(bus_if.mst));
   all_slave all_slave_inst (.sys_clk(sys_clk), .rst(rst),
      .strb_policy(strb_policy), .wr_count(wr_count), .bus(bus_if.slv));
   all_properties all_properties_inst (.sys_clk(sys_clk), .rst(rst),
      .awvalid(bus_if.awvalid), .awready(bus_if.awready),
      .awid(bus_if.awid), .bvalid(bus_if.bvalid), .bready(bus_if.bready),
      .bresp(bus_if.bresp), .bid(bus_if.bid), .arvalid(bus_if.arvalid),
      .arready(bus_if.arready), .arid(bus_if.arid),
      .rvalid(bus_if.rvalid), .rready(bus_if.rready),
      .rresp(bus_if.rresp), .rid(bus_if.rid));
   // ---------------------------------------------------------------
   // clock, verdict and access tasks
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // one access; req is held for one sampling edge, then done is awaited
   task access(input logic w, input all_addr_type a, input all_data_type d,
      input all_strb_type s, input all_id_type id);
      int n;
      @(negedge sys_clk);
      `CHK(busy, 1'b0)
      req = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_strb = s;
      req_id = id;
      @(negedge sys_clk);
      req = 1'b0;
      `CHK(busy, 1'b1)
      n = 0;
      while (done !== 1'b1 && n < 50) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= 50) begin
         bad_count++;
         print_verdict();
      end else begin
         @(negedge sys_clk);
      end
   endtask
   task wr(input all_addr_type a, input all_data_type d,
      input all_strb_type s, input all_id_type id, input all_resp_type r);
      access(1'b1, a, d, s, id);
      `CHK(done_resp, r)
      `CHK(done_id, id)
   endtask
   task rd(input all_addr_type a, input all_id_type id,
      input all_data_type e);
      access(1'b0, a, 32'h0, 4'h0, id);
      `CHK(done_rdata, e)
      `CHK(done_resp, `ALL_RESP_OKAY)
      `CHK(done_id, id)
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      bad_count = 0;
      cmp_count = 0;
      rst = 1'b1;
      req = 1'b0;
      req_write = 1'b0;
      req_addr = 12'h0;
      req_wdata = 32'h0;
      req_strb = 4'h0;
      req_id = 4'h0;
      strb_policy = `ALL_POL_FULL;
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      wr(12'h010, 32'h11223344, 4'hf, 4'h3, `ALL_RESP_OKAY);
      `CHK(wr_count, 8'h01)
      rd(12'h010, 4'h5, 32'h11223344);
      wr(12'h010, 32'haabbccdd, 4'h1, 4'h6, `ALL_RESP_OKAY);
      rd(12'h010, 4'h7, 32'h112233dd);
      wr(12'h010, 32'heeff0000, 4'hc, 4'h8, `ALL_RESP_OKAY);
      rd(12'h010, 4'h9, 32'heeff33dd);
      wr(12'h010, 32'h0, 4'h0, 4'ha, `ALL_RESP_OKAY);
      rd(12'h010, 4'hb, 32'heeff33dd);
      strb_policy = `ALL_POL_IGNORE;
      wr(12'h0fc, 32'h55667788, 4'h1, 4'hc, `ALL_RESP_OKAY);
      rd(12'h0fc, 4'hd, 32'h55667788);
      strb_policy = `ALL_POL_DETECT;
      wr(12'h0fc, 32'h12345678, 4'h3, 4'he, `ALL_RESP_SLVERR);
      rd(12'h0fc, 4'hf, 32'h55667788);
      wr(12'h0fc, 32'h9abcdef0, 4'hf, 4'h0, `ALL_RESP_OKAY);
      rd(12'h0fc, 4'h1, 32'h9abcdef0);
      wr(12'h0fc, 32'h0, 4'h0, 4'h2, `ALL_RESP_OKAY);
      rd(12'h0fc, 4'h4, 32'h9abcdef0);
      // a second reset in mid-run must bring back a working link
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      rd(12'h0fc, 4'h3, 32'h9abcdef0);
      print_verdict();
   end
endmodule
